// ===== design/hspb_device.sv
`default_nettype none
module hspb_device
    import hspb_pkg::*;
#(
    parameter int GUARD_CYCLES = GUARD_CYC
) (
    input  wire logic       CLK,
    input  wire logic       RESETN,
    hspb_if.dev             LINK,
    input  wire logic       CTS_EN,
    input  wire logic       RTS_EN,
    input  wire logic       API_MODE,
    input  wire logic [8:0] FLOW_THRESHOLD,
    input  wire logic [7:0] PACKETIZE_TIMEOUT,
    output logic      [7:0] TX_DATA,
    output logic            TX_VALID,
    output logic            TX_LAST,
    input  wire logic       TX_READY,
    input  wire logic       RF_BUSY,
    input  wire logic [7:0] RF_DATA,
    input  wire logic       RF_VALID,
    input  wire logic       RF_LAST,
    output logic            RF_DROP,
    output logic            CMD_SEQ
);
    logic                din_s1_r, din_s2_r, rts_s1_r, rts_s2_r;
    hspb_rx_t            rx_st_r;
    logic [CNT_W-1:0]    rx_cnt_r;
    logic [2:0]          rx_bit_r;
    logic [7:0]          rx_sh_r;
    logic                rx_done_r;
    logic [7:0]          rxq_mem [RXQ_DEPTH];
    logic [RXQ_AW-1:0]   rxq_wp_r, rxq_rp_r;
    logic [RXQ_AW:0]     rxq_cnt_r;
    logic                push, pop, send, discard, can_send;
    logic [RXQ_AW:0]     pkt_left_r, avail;
    logic [1:0]          disc_r;
    logic                pend_r, trig;
    logic [CNT_W-1:0]    bt_cnt_r;
    logic [7:0]          idle_bits_r;
    logic [GUARD_W-1:0]  g_cnt_r;
    logic                guard_ok;
    logic [1:0]          seq_r;
    logic                cts_n_r;
    logic [7:0]          txq_mem [TXQ_DEPTH];
    logic [TXQ_AW:0]     txq_wpt_r, txq_wpc_r, txq_rp_r;
    logic                drop_r, txq_full;
    logic                tx_busy_r, dout_r;
    logic [8:0]          tx_sh_r;
    logic [3:0]          tx_bits_r;
    logic [CNT_W-1:0]    tx_cnt_r;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            din_s1_r <= LINE_IDLE;
            din_s2_r <= LINE_IDLE;
            rts_s1_r <= 1'b0;
            rts_s2_r <= 1'b0;
        end else begin
            din_s1_r <= LINK.din;
            din_s2_r <= din_s1_r;
            rts_s1_r <= LINK.rts_n;
            rts_s2_r <= rts_s1_r;
        end
    end

    // Receiver samples mid-bit; a low stop bit discards the character.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rx_st_r   <= RX_IDLE;
            rx_cnt_r  <= '0;
            rx_bit_r  <= '0;
            rx_sh_r   <= '0;
            rx_done_r <= 1'b0;
        end else begin
            rx_done_r <= 1'b0;
            if (rx_st_r != RX_IDLE) begin
                rx_cnt_r <= (rx_cnt_r == '0) ? BIT_M1 : rx_cnt_r - 1'b1;
            end
            unique case (rx_st_r)
                RX_IDLE: if (!din_s2_r) begin
                    rx_cnt_r <= HALF_M1;
                    rx_st_r  <= RX_START;
                end
                RX_START: if (rx_cnt_r == '0) begin
                    rx_bit_r <= '0;
                    rx_st_r  <= din_s2_r ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (rx_cnt_r == '0) begin
                    rx_sh_r  <= {din_s2_r, rx_sh_r[7:1]};
                    rx_bit_r <= rx_bit_r + 1'b1;
                    if (rx_bit_r == 3'h7) begin
                        rx_st_r <= RX_STOP;
                    end
                end
                RX_STOP: if (rx_cnt_r == '0) begin
                    rx_done_r <= din_s2_r;
                    rx_st_r   <= RX_IDLE;
                end
            endcase
        end
    end

    assign push     = rx_done_r && (rxq_cnt_r != (RXQ_AW+1)'(RXQ_DEPTH));
    assign can_send = (rxq_cnt_r != '0) && (pkt_left_r != '0) && !RF_BUSY;
    assign send     = can_send && (!TX_VALID || TX_READY);
    assign discard  = (disc_r != '0) && (pkt_left_r == '0) && !pend_r && (rxq_cnt_r != '0);
    assign pop      = send || discard;

    always_ff @(posedge CLK) begin
        if (push) begin
            rxq_mem[rxq_wp_r] <= rx_sh_r;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rxq_wp_r  <= '0;
            rxq_rp_r  <= '0;
            rxq_cnt_r <= '0;
        end else begin
            rxq_wp_r  <= rxq_wp_r + RXQ_AW'(push);
            rxq_rp_r  <= rxq_rp_r + RXQ_AW'(pop);
            rxq_cnt_r <= rxq_cnt_r + (RXQ_AW+1)'(push) - (RXQ_AW+1)'(pop);
        end
    end

    // Radio-side byte stream; a packet ends on the byte marked last.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            TX_DATA  <= '0;
            TX_VALID <= 1'b0;
            TX_LAST  <= 1'b0;
        end else if (!TX_VALID || TX_READY) begin
            TX_VALID <= send;
            TX_DATA  <= rxq_mem[rxq_rp_r];
            TX_LAST  <= send && (pkt_left_r == (RXQ_AW+1)'(1));
        end
    end

    // Idle gap measured in bit times since the last received character.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            bt_cnt_r    <= '0;
            idle_bits_r <= '0;
            g_cnt_r     <= '0;
        end else begin
            bt_cnt_r <= (bt_cnt_r == '0 || rx_done_r) ? BIT_M1 : bt_cnt_r - 1'b1;
            if (rx_done_r) begin
                idle_bits_r <= '0;
                g_cnt_r     <= '0;
            end else begin
                if (bt_cnt_r == '0 && idle_bits_r != 8'hFF) begin
                    idle_bits_r <= idle_bits_r + 1'b1;
                end
                if (!guard_ok) begin
                    g_cnt_r <= g_cnt_r + 1'b1;
                end
            end
        end
    end

    assign guard_ok = (g_cnt_r == GUARD_W'(GUARD_CYCLES));

    // Guard, three command characters, guard; API mode ignores it.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            seq_r   <= '0;
            CMD_SEQ <= 1'b0;
        end else begin
            CMD_SEQ <= 1'b0;
            if (API_MODE) begin
                seq_r <= '0;
            end else if (rx_done_r) begin
                if (rx_sh_r != CMD_CHAR) begin
                    seq_r <= '0;
                end else if (seq_r == '0) begin
                    seq_r <= guard_ok ? 2'h1 : 2'h0;
                end else if (seq_r != CMD_CHAR_CNT) begin
                    seq_r <= seq_r + 1'b1;
                end else begin
                    seq_r <= '0;
                end
            end else if (seq_r == CMD_CHAR_CNT && guard_ok) begin
                seq_r   <= '0;
                CMD_SEQ <= 1'b1;
            end
        end
    end

    always_comb begin
        trig = 1'b0;
        if (API_MODE) begin
            trig = rxq_cnt_r != '0;
        end else begin
            if (PACKETIZE_TIMEOUT == '0 && rxq_cnt_r != '0) begin
                trig = 1'b1;
            end
            if (idle_bits_r >= PACKETIZE_TIMEOUT && bt_cnt_r == '0 && rxq_cnt_r != '0) begin
                trig = 1'b1;
            end
            if (rxq_cnt_r >= (RXQ_AW+1)'(MAX_PAYLOAD)) begin
                trig = 1'b1;
            end
        end
    end

    assign avail = rxq_cnt_r - (RXQ_AW+1)'(disc_r);

    // Packets hold at most the payload size; the sequence is dropped only if no trigger packetized it by the CMD_SEQ cycle.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            pend_r     <= 1'b0;
            pkt_left_r <= '0;
            disc_r     <= '0;
        end else begin
            if (CMD_SEQ) begin
                pend_r <= 1'b1;
                disc_r <= CMD_CHAR_CNT;
            end else if (discard) begin
                disc_r <= disc_r - 1'b1;
            end
            if (pkt_left_r == '0) begin
                if (pend_r || trig) begin
                    if (avail > (RXQ_AW+1)'(MAX_PAYLOAD)) begin
                        pkt_left_r <= (RXQ_AW+1)'(MAX_PAYLOAD);
                        pend_r     <= 1'b1;
                    end else begin
                        pkt_left_r <= avail;
                        pend_r     <= CMD_SEQ;
                    end
                end
            end else if (send) begin
                pkt_left_r <= pkt_left_r - 1'b1;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cts_n_r <= 1'b0;
        end else if (!CTS_EN) begin
            cts_n_r <= 1'b0;
        end else if ({1'b0, rxq_cnt_r} >= {1'b0, FLOW_THRESHOLD}) begin
            cts_n_r <= 1'b1;
        end else if ({1'b0, rxq_cnt_r} + 10'(FLOW_HYST) < {1'b0, FLOW_THRESHOLD}) begin
            cts_n_r <= 1'b0;
        end
    end

    assign txq_full = (txq_wpt_r - txq_rp_r) == (TXQ_AW+1)'(TXQ_DEPTH);

    always_ff @(posedge CLK) begin
        if (RF_VALID && !drop_r && !txq_full) begin
            txq_mem[txq_wpt_r[TXQ_AW-1:0]] <= RF_DATA;
        end
    end

    // Bytes stay uncommitted until the last one fits; otherwise rewind.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            txq_wpt_r <= '0;
            txq_wpc_r <= '0;
            drop_r    <= 1'b0;
            RF_DROP   <= 1'b0;
        end else begin
            RF_DROP <= 1'b0;
            if (RF_VALID) begin
                if (RF_LAST) begin
                    drop_r <= 1'b0;
                    if (drop_r || txq_full) begin
                        txq_wpt_r <= txq_wpc_r;
                        RF_DROP   <= 1'b1;
                    end else begin
                        txq_wpt_r <= txq_wpt_r + 1'b1;
                        txq_wpc_r <= txq_wpt_r + 1'b1;
                    end
                end else if (drop_r || txq_full) begin
                    drop_r <= 1'b1;
                end else begin
                    txq_wpt_r <= txq_wpt_r + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            tx_busy_r <= 1'b0;
            dout_r    <= LINE_IDLE;
            tx_sh_r   <= '1;
            tx_bits_r <= '0;
            tx_cnt_r  <= '0;
            txq_rp_r  <= '0;
        end else if (!tx_busy_r) begin
            if (txq_rp_r != txq_wpc_r && !(RTS_EN && rts_s2_r)) begin
                tx_busy_r <= 1'b1;
                dout_r    <= 1'b0;
                tx_sh_r   <= {1'b1, txq_mem[txq_rp_r[TXQ_AW-1:0]]};
                tx_bits_r <= 4'h9;
                tx_cnt_r  <= BIT_M1;
                txq_rp_r  <= txq_rp_r + 1'b1;
            end
        end else if (tx_cnt_r != '0) begin
            tx_cnt_r <= tx_cnt_r - 1'b1;
        end else if (tx_bits_r == '0) begin
            tx_busy_r <= 1'b0;
        end else begin
            dout_r    <= tx_sh_r[0];
            tx_sh_r   <= {1'b1, tx_sh_r[8:1]};
            tx_bits_r <= tx_bits_r - 1'b1;
            tx_cnt_r  <= BIT_M1;
        end
    end

    assign LINK.dout  = dout_r;
    assign LINK.cts_n = cts_n_r;
endmodule
`default_nettype wire

// ===== design/hspb_host.sv
`default_nettype none
module hspb_host
    import hspb_pkg::*;
#(
    parameter int GUARD_CYCLES = GUARD_CYC
) (
    input  wire logic       CLK,
    input  wire logic       RESETN,
    hspb_if.host            LINK,
    input  wire logic [7:0] SEND_DATA,
    input  wire logic       SEND_VALID,
    output logic            SEND_READY,
    output logic      [7:0] RECV_DATA,
    output logic            RECV_VALID,
    input  wire logic       HOLD_OFF,
    input  wire logic       CMD_REQ,
    output logic            CMD_BUSY
);
    logic               dout_s1_r, dout_s2_r, cts_s1_r, cts_s2_r;
    hspb_rx_t           rx_st_r;
    logic [CNT_W-1:0]   rx_cnt_r;
    logic [2:0]         rx_bit_r;
    logic [7:0]         rx_sh_r;
    hspb_cs_t           cs_r;
    logic [GUARD_W-1:0] g_cnt_r;
    logic [1:0]         chars_r;
    logic               take, cmd_go, rts_n_r;
    logic               tx_busy_r, din_r;
    logic [8:0]         tx_sh_r;
    logic [3:0]         tx_bits_r;
    logic [CNT_W-1:0]   tx_cnt_r;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            dout_s1_r <= LINE_IDLE;
            dout_s2_r <= LINE_IDLE;
            cts_s1_r  <= 1'b1;
            cts_s2_r  <= 1'b1;
            rts_n_r   <= 1'b0;
        end else begin
            dout_s1_r <= LINK.dout;
            dout_s2_r <= dout_s1_r;
            cts_s1_r  <= LINK.cts_n;
            cts_s2_r  <= cts_s1_r;
            rts_n_r   <= HOLD_OFF;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rx_st_r    <= RX_IDLE;
            rx_cnt_r   <= '0;
            rx_bit_r   <= '0;
            rx_sh_r    <= '0;
            RECV_DATA  <= '0;
            RECV_VALID <= 1'b0;
        end else begin
            RECV_VALID <= 1'b0;
            if (rx_st_r != RX_IDLE) begin
                rx_cnt_r <= (rx_cnt_r == '0) ? BIT_M1 : rx_cnt_r - 1'b1;
            end
            unique case (rx_st_r)
                RX_IDLE: if (!dout_s2_r) begin
                    rx_cnt_r <= HALF_M1;
                    rx_st_r  <= RX_START;
                end
                RX_START: if (rx_cnt_r == '0) begin
                    rx_bit_r <= '0;
                    rx_st_r  <= dout_s2_r ? RX_IDLE : RX_DATA;
                end
                RX_DATA: if (rx_cnt_r == '0) begin
                    rx_sh_r  <= {dout_s2_r, rx_sh_r[7:1]};
                    rx_bit_r <= rx_bit_r + 1'b1;
                    if (rx_bit_r == 3'h7) begin
                        rx_st_r <= RX_STOP;
                    end
                end
                RX_STOP: if (rx_cnt_r == '0) begin
                    RECV_VALID <= dout_s2_r;
                    RECV_DATA  <= rx_sh_r;
                    rx_st_r    <= RX_IDLE;
                end
            endcase
        end
    end

    assign take   = SEND_VALID && SEND_READY;
    assign cmd_go = (cs_r == CS_CHARS) && !tx_busy_r && (chars_r != '0) && !cts_s2_r;

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            SEND_READY <= 1'b0;
        end else begin
            SEND_READY <= (cs_r == CS_IDLE) && !CMD_REQ && !tx_busy_r && !cts_s2_r && !take;
        end
    end

    // Line silence is counted from the end of the last stop bit.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            cs_r     <= CS_IDLE;
            g_cnt_r  <= '0;
            chars_r  <= '0;
            CMD_BUSY <= 1'b0;
        end else begin
            g_cnt_r <= (tx_busy_r || take || cmd_go) ? '0 :
                       (g_cnt_r == GUARD_W'(GUARD_CYCLES)) ? g_cnt_r : g_cnt_r + 1'b1;
            unique case (cs_r)
                CS_IDLE: if (CMD_REQ && !take) begin
                    cs_r     <= CS_GUARD1;
                    CMD_BUSY <= 1'b1;
                end
                CS_GUARD1: if (g_cnt_r == GUARD_W'(GUARD_CYCLES) && !tx_busy_r) begin
                    cs_r    <= CS_CHARS;
                    chars_r <= CMD_CHAR_CNT;
                end
                CS_CHARS: begin
                    if (cmd_go) begin
                        chars_r <= chars_r - 1'b1;
                    end
                    if (chars_r == '0 && !tx_busy_r) begin
                        cs_r <= CS_GUARD2;
                    end
                end
                CS_GUARD2: if (g_cnt_r == GUARD_W'(GUARD_CYCLES)) begin
                    cs_r     <= CS_IDLE;
                    CMD_BUSY <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            tx_busy_r <= 1'b0;
            din_r     <= LINE_IDLE;
            tx_sh_r   <= '1;
            tx_bits_r <= '0;
            tx_cnt_r  <= '0;
        end else if (!tx_busy_r) begin
            if (take || cmd_go) begin
                tx_busy_r <= 1'b1;
                din_r     <= 1'b0;
                tx_sh_r   <= {1'b1, cmd_go ? CMD_CHAR : SEND_DATA};
                tx_bits_r <= 4'h9;
                tx_cnt_r  <= BIT_M1;
            end
        end else if (tx_cnt_r != '0) begin
            tx_cnt_r <= tx_cnt_r - 1'b1;
        end else if (tx_bits_r == '0) begin
            tx_busy_r <= 1'b0;
        end else begin
            din_r     <= tx_sh_r[0];
            tx_sh_r   <= {1'b1, tx_sh_r[8:1]};
            tx_bits_r <= tx_bits_r - 1'b1;
            tx_cnt_r  <= BIT_M1;
        end
    end

    assign LINK.din   = din_r;
    assign LINK.rts_n = rts_n_r;
endmodule
`default_nettype wire

// ===== design/hspb_if.sv
`default_nettype none
interface hspb_if;
    logic din;
    logic dout;
    logic cts_n;
    logic rts_n;
    modport dev (input din, input rts_n, output dout, output cts_n);
    modport host (output din, output rts_n, input dout, input cts_n);
endinterface
`default_nettype wire

// ===== design/hspb_pkg.sv
`default_nettype none
package hspb_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int BAUD = 9600;
    localparam int BIT_CYC = CLK_HZ / BAUD;
    localparam int HALF_CYC = BIT_CYC / 2;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] BIT_M1 = CNT_W'(BIT_CYC - 1);
    localparam logic [CNT_W-1:0] HALF_M1 = CNT_W'(HALF_CYC - 1);
    localparam int GUARD_TIME_MS = 'h3E8;
    localparam int GUARD_CYC = (CLK_HZ / 1000) * GUARD_TIME_MS;
    localparam int GUARD_W = 25;
    localparam logic [7:0] CMD_CHAR = 8'h2B;
    localparam logic [1:0] CMD_CHAR_CNT = 2'h3;
    localparam int FLOW_HYST = 16;
    localparam int RXQ_AW = 8;
    localparam int TXQ_AW = 8;
    localparam int RXQ_DEPTH = 1 << RXQ_AW;
    localparam int TXQ_DEPTH = 1 << TXQ_AW;
    localparam int MAX_PAYLOAD = 64;
    localparam logic LINE_IDLE = 1'b1;
    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } hspb_rx_t;
    typedef enum logic [3:0] {
        CS_IDLE   = 4'h1,
        CS_GUARD1 = 4'h2,
        CS_CHARS  = 4'h4,
        CS_GUARD2 = 4'h8
    } hspb_cs_t;
endpackage
`default_nettype wire

// ===== verif/host_serial_port_buffering_tb.sv
`default_nettype none
module host_serial_port_buffering_tb import hspb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       cts_en = 1'b0;
    logic       rts_en = 1'b0;
    logic       hold_off = 1'b0;
    logic [8:0] flow_threshold = 9'h001;
    logic [7:0] packetize_timeout = 8'h00;
    logic       tx_ready = 1'b1;
    logic       rf_busy = 1'b0;
    logic [7:0] rf_data = 8'h00;
    logic       rf_valid = 1'b0;
    logic       rf_last = 1'b0;
    logic [7:0] send_data = 8'h00;
    logic       send_valid = 1'b0;
    logic [7:0] tx_data;
    logic [7:0] recv_data;
    logic       tx_valid;
    logic       tx_last;
    logic       send_ready;
    logic       recv_valid;
    logic       rf_drop;
    logic       cmd_seq;
    logic       cmd_busy;
    int         num_errors = 0;
    int         checks_done = 0;
    int         seed = 44;
    int         drops = 0;
    int         seqs = 0;
    logic [8:0] txq[$];
    logic [7:0] rxq[$];
    hspb_if hspb_if_i ();
    hspb_device #(.GUARD_CYCLES(500)) hspb_device_i (.CLK(clk), .RESETN(resetn),
        .LINK(hspb_if_i), .CTS_EN(cts_en), .RTS_EN(rts_en), .API_MODE(1'b0),
        .FLOW_THRESHOLD(flow_threshold), .PACKETIZE_TIMEOUT(packetize_timeout),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_LAST(tx_last), .TX_READY(tx_ready),
        .RF_BUSY(rf_busy), .RF_DATA(rf_data), .RF_VALID(rf_valid), .RF_LAST(rf_last),
        .RF_DROP(rf_drop), .CMD_SEQ(cmd_seq));
    hspb_host #(.GUARD_CYCLES(500)) hspb_host_i (.CLK(clk), .RESETN(resetn),
        .LINK(hspb_if_i), .SEND_DATA(send_data), .SEND_VALID(send_valid),
        .SEND_READY(send_ready), .RECV_DATA(recv_data), .RECV_VALID(recv_valid),
        .HOLD_OFF(hold_off), .CMD_REQ(1'b0), .CMD_BUSY(cmd_busy));
    hspb_sva hspb_sva_i (.CLK(clk), .RESETN(resetn), .dout(hspb_if_i.dout),
        .cts_n(hspb_if_i.cts_n), .rts_n(hspb_if_i.rts_n), .CTS_EN(cts_en), .RTS_EN(rts_en),
        .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_LAST(tx_last), .TX_READY(tx_ready),
        .RF_BUSY(rf_busy), .RF_VALID(rf_valid), .RF_LAST(rf_last), .RF_DROP(rf_drop));
    always #25 clk = ~clk;
    always @(negedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back({tx_last, tx_data});
        if (recv_valid === 1'b1) rxq.push_back(recv_data);
        if (rf_drop === 1'b1) drops++;
        if (cmd_seq === 1'b1) seqs++;
    end
    function automatic logic frame_bit(input logic [7:0] b, input int k);
        if (k == 0) return 1'b0;
        if (k == 9) return 1'b1;
        return b[k - 1];
    endfunction
    function automatic logic [8:0] pkt_byte(input logic [7:0] b, input logic last);
        return {last, b};
    endfunction
    function automatic logic line(input logic sel);
        return sel ? hspb_if_i.dout : hspb_if_i.din;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic send_byte(input logic [7:0] b);
        send_data = b;
        send_valid = 1'b1;
        for (int n = 0; n < 9000 && send_ready !== 1'b1; n++) tick(1);
        tick(1);
        send_valid = 1'b0;
    endtask
    task automatic rf_put(input logic [7:0] b, input logic last);
        rf_data = b;
        rf_valid = 1'b1;
        rf_last = last;
        tick(1);
    endtask
    // Samples one frame at mid-bit and compares every slot with the expected byte.
    task automatic grab(input logic sel, input logic [7:0] e);
        for (int n = 0; n < 30000 && line(sel) !== 1'b0; n++) tick(1);
        tick(HALF_CYC);
        for (int k = 0; k < 10; k++) begin
            check("frame bit", 16'(line(sel)), 16'(frame_bit(e, k)));
            if (k < 9) tick(BIT_CYC);
        end
    endtask
    task automatic wait_tx(output int n);
        for (n = 0; n < 20000 && tx_valid !== 1'b1; n++) tick(1);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        end_of_test();
    end
    initial begin
        logic [7:0] b;
        logic [7:0] r;
        logic [7:0] first;
        int         n;
        tick(3);
        resetn = 1'b1;
        tick(2);
        b = 8'($random(seed));
        r = 8'($random(seed));
        cts_en = 1'b1;
        rf_busy = 1'b1;
        fork
            send_byte(b);
            grab(1'b0, b);
            begin
                rf_put(r, 1'b1);
                rf_valid = 1'b0;
            end
            grab(1'b1, r);
        join
        tick(BIT_CYC);
        check("cts_n", 16'(hspb_if_i.cts_n), 16'h0001);
        check("early tx", 16'(txq.size()), 16'h0000);
        check("recv", 16'(rxq.pop_front()), 16'(r));
        tx_ready = 1'b0;
        rf_busy = 1'b0;
        wait_tx(n);
        tick(4);
        check("tx held", 16'(tx_valid), 16'h0001);
        check("tx unsent", 16'(txq.size()), 16'h0000);
        tx_ready = 1'b1;
        tick(2);
        check("tx byte", 16'(txq.pop_front()), 16'(pkt_byte(b, 1'b1)));
        check("cts_n held", 16'(hspb_if_i.cts_n), 16'h0001);
        $display("test per_char done");
        cts_en = 1'b0;
        packetize_timeout = 8'h02;
        b = 8'($random(seed));
        fork
            send_byte(b);
            grab(1'b0, b);
        join
        wait_tx(n);
        check("gap long", 16'(n >= 2 * BIT_CYC + HALF_CYC), 16'h0001);
        check("gap bounded", 16'(n <= 4 * BIT_CYC), 16'h0001);
        tick(2);
        check("tx byte", 16'(txq.pop_front()), 16'(pkt_byte(b, 1'b1)));
        $display("test gap done");
        rts_en = 1'b1;
        hold_off = 1'b1;
        tick(8);
        first = 8'($random(seed));
        // A full 256-byte packet fits exactly; the one-byte packet after it cannot.
        for (int i = 0; i < 257; i++) rf_put(i == 0 ? first : 8'($random(seed)), 1'(i >= 255));
        rf_valid = 1'b0;
        tick(3);
        check("drops", 16'(drops), 16'h0001);
        tick(BIT_CYC);
        check("dout held", 16'(hspb_if_i.dout), 16'h0001);
        hold_off = 1'b0;
        grab(1'b1, first);
        check("cmd seq", 16'(seqs), 16'h0000);
        check("cmd busy", 16'(cmd_busy), 16'h0000);
        $display("test hold_drop done");
        end_of_test();
    end
endmodule
`default_nettype wire

// ===== verif/hspb_sva.sv
`default_nettype none
module hspb_sva
    import hspb_pkg::*;
(
    input wire logic       CLK,
    input wire logic       RESETN,
    input wire logic       dout,
    input wire logic       cts_n,
    input wire logic       rts_n,
    input wire logic       CTS_EN,
    input wire logic       RTS_EN,
    input wire logic [7:0] TX_DATA,
    input wire logic       TX_VALID,
    input wire logic       TX_LAST,
    input wire logic       TX_READY,
    input wire logic       RF_BUSY,
    input wire logic       RF_VALID,
    input wire logic       RF_LAST,
    input wire logic       RF_DROP
);
    localparam int IDLE_CYC = 10 * BIT_CYC;
    localparam int LOW_MAX = 9 * BIT_CYC;
    logic [15:0] hi_cnt_r;
    logic [15:0] lo_cnt_r;
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESETN);
    // A long high run tells a quiet line apart from the high bits inside a frame.
    always_ff @(posedge CLK) begin
        if (!RESETN || !dout) begin
            hi_cnt_r <= 16'h0000;
        end else if (hi_cnt_r != 16'hFFFF) begin
            hi_cnt_r <= hi_cnt_r + 16'h0001;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RESETN || dout) begin
            lo_cnt_r <= 16'h0000;
        end else begin
            lo_cnt_r <= lo_cnt_r + 16'h0001;
        end
    end
    property p_start_bit; $fell(dout) |=> !dout [*8]; endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("start bit ended early");
    property p_low_max; lo_cnt_r <= LOW_MAX; endproperty
    a_low_max: assert property (p_low_max)
        else $error("output line low past the stop bit");
    property p_rts_hold; (RTS_EN && rts_n) [*5] ##0 (hi_cnt_r > IDLE_CYC) |=> dout; endproperty
    a_rts_hold: assert property (p_rts_hold)
        else $error("character started while held off");
    property p_cts_off; !CTS_EN [*2] |-> !cts_n; endproperty
    a_cts_off: assert property (p_cts_off)
        else $error("cts_n high with flow control off");
    property p_cts_src; $rose(cts_n) |-> $past(CTS_EN); endproperty
    a_cts_src: assert property (p_cts_src)
        else $error("cts_n rose with flow control off");
    property p_tx_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("radio byte lost before acceptance");
    property p_busy; $rose(TX_VALID) |-> !$past(RF_BUSY); endproperty
    a_busy: assert property (p_busy)
        else $error("byte offered while radio busy");
    property p_drop; RF_DROP |-> $past(RF_VALID && RF_LAST) && !$past(RF_DROP); endproperty
    a_drop: assert property (p_drop)
        else $error("drop pulse not tied to packet end");
endmodule
`default_nettype wire
